/* File: rtl/iepr_arb.sv */
// Priority arbiter over the prioritised sources.
// Assumes requests already gated; level zero never wins.
`timescale 1ns/1ps

module iepr_arb #(
  parameter int N = 15
) (
  input  wire logic [N-1:0]   req,
  input  wire logic [3*N-1:0] lvl,
  output      logic           any,
  output      logic [2:0]     win_lvl,
  output      logic [4:0]     win_id
);

  // ----------------------------------------------------------------
  // Highest code wins, lowest index on a tie
  // ----------------------------------------------------------------
  always_comb begin
    any     = 1'b0;
    win_lvl = iepr_pkg::LVL_OFF;
    win_id  = 5'h00;
    for (int i = 0; i < N; i++) begin
      // Strict greater keeps the lowest index among equals
      if (req[i] && (lvl[3*i +: 3] > win_lvl)) begin // R8 R2
        any     = 1'b1;
        win_lvl = lvl[3*i +: 3]; // R3
        win_id  = 5'(i);
      end
    end
  end

endmodule // iepr_arb

/* File: rtl/iepr_pkg.sv */
// Constants for the interrupt enable and priority register slice.
// Assumes an APB master on pclk; sources sit outside, the arbiter inside iepr_top.
// What this block does
// (R1) Enable bit 1 passes request, 0 blocks
// (R2) Priority code zero disables the source entirely
// (R3) Codes one to seven map to levels linearly
// (R4) Unimplemented and spare bits ignore writes, read zero
// (R5) Word3 bit 14 gates calendar request only
// (R6) Word3 bit 13 gates DMA channel 5
// (R7) Without CAN, CAN enables have no effect
// (R8) Code seven is highest; higher code wins
// (R9) Reset clears enables, priorities load level four
package iepr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EN3   = 8'h00; // Enable word 3
  localparam logic [7:0] OFS_EN4   = 8'h04; // Enable word 4
  localparam logic [7:0] OFS_PRI0  = 8'h08; // Priority word 0
  localparam logic [7:0] OFS_PRI1  = 8'h0c; // Priority word 1
  localparam logic [7:0] OFS_PRI2  = 8'h10; // Priority word 2
  localparam logic [7:0] OFS_PRI3  = 8'h14; // Priority word 3
  localparam logic [7:0] OFS_STAT  = 8'h18; // Sticky event status
  localparam logic [7:0] OFS_CLR   = 8'h1c; // Write one to clear
  localparam logic [7:0] OFS_IEN   = 8'h20; // Event interrupt enable

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EN3_MASK  = 16'h6000; // Bits 14 and 13
  localparam logic [15:0] EN4_MASK  = 16'h007e; // Bits 6 down to 1
  localparam logic [15:0] PRI_MASK  = 16'h7777; // Spare bits cleared
  localparam logic [15:0] PRI3_MASK = 16'h0777; // Bits 15..11 spare
  localparam logic [15:0] EN_RST    = 16'h0000; // Enables cleared
  localparam logic [15:0] PRI_RST   = 16'h4444; // Level four
  localparam logic [15:0] PRI3_RST  = 16'h0444; // Level four
  localparam int          EN3_CAL   = 14;       // Calendar gate
  localparam int          EN3_DMA5  = 13;       // DMA ch5 gate
  localparam int          EN4_CANTX = 6;        // CAN tx gate
  localparam logic [2:0]  LVL_OFF   = 3'h0;     // Source disabled
  localparam int          NSRC      = 15;       // Prioritised sources
  localparam int          NEVT      = 2;        // Status event bits
  localparam int          EVT_PSLV  = 0;      // Bad address access
  localparam int          EVT_WIN   = 1;      // New winner pending

  // Decoded APB register select
  typedef enum logic [9:0] {
    IEPR_S_EN3  = 10'h001,
    IEPR_S_EN4  = 10'h002,
    IEPR_S_PRI0 = 10'h004,
    IEPR_S_PRI1 = 10'h008,
    IEPR_S_PRI2 = 10'h010,
    IEPR_S_PRI3 = 10'h020,
    IEPR_S_STAT = 10'h040,
    IEPR_S_CLR  = 10'h080,
    IEPR_S_IEN  = 10'h100,
    IEPR_S_NONE = 10'h200
  } iepr_sel_e;

endpackage

/* File: rtl/iepr_top.sv */
// Enable and priority register slice with APB access and arbitration.
// Assumes flags come in as levels synchronous to pclk.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps

module iepr_top #(
  parameter bit HAS_CAN = 1'b1 // Variant carries the CAN controller
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic [15:0] flag3,
  input  wire logic [15:0] flag4,
  input  wire logic [14:0] src_flag,
  output      logic [15:0] req3,
  output      logic [15:0] req4,
  output      logic        cpu_irq,
  output      logic [2:0]  cpu_lvl,
  output      logic [4:0]  cpu_id,
  output      logic        irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]           en3;    // Enable word 3
    logic [15:0]           en4;    // Enable word 4
    logic [3:0][15:0]      pri;    // Priority words 0..3
    logic [iepr_pkg::NEVT-1:0] stat; // Sticky events
    logic [iepr_pkg::NEVT-1:0] ien;  // Event enables
    logic [31:0]           rdata;  // Read data
    logic                  ready;  // Access phase answer
    logic                  err;    // Slave error
    logic [15:0]           req3;   // Gated word 3 requests
    logic [15:0]           req4;   // Gated word 4 requests
    logic                  cirq;   // Processor request
    logic [2:0]            clvl;   // Winning level
    logic [4:0]            cid;    // Winning source
    logic                  irq;    // Event interrupt
  } iepr_state_s;

  iepr_state_s st_r;  // Registered state
  iepr_state_s st_nxt; // Next state

  logic            arb_any; // Some gated source has a level
  logic [2:0]      arb_lvl; // Arbiter level
  logic [4:0]      arb_id;  // Arbiter winner
  logic [14:0]     src_req; // Priority-gated requests
  logic [44:0]     src_lvl; // Levels packed per source

  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ----------------------------------------------------------------
  function automatic iepr_pkg::iepr_sel_e dec(input logic [7:0] a);
    case (a)
      iepr_pkg::OFS_EN3:  dec = iepr_pkg::IEPR_S_EN3;
      iepr_pkg::OFS_EN4:  dec = iepr_pkg::IEPR_S_EN4;
      iepr_pkg::OFS_PRI0: dec = iepr_pkg::IEPR_S_PRI0;
      iepr_pkg::OFS_PRI1: dec = iepr_pkg::IEPR_S_PRI1;
      iepr_pkg::OFS_PRI2: dec = iepr_pkg::IEPR_S_PRI2;
      iepr_pkg::OFS_PRI3: dec = iepr_pkg::IEPR_S_PRI3;
      iepr_pkg::OFS_STAT: dec = iepr_pkg::IEPR_S_STAT;
      iepr_pkg::OFS_CLR:  dec = iepr_pkg::IEPR_S_CLR;
      iepr_pkg::OFS_IEN:  dec = iepr_pkg::IEPR_S_IEN;
      default:            dec = iepr_pkg::IEPR_S_NONE;
    endcase
  endfunction

  // Implemented bits of a priority word
  function automatic logic [15:0] pmask(input int k);
    pmask = (k == 3) ? iepr_pkg::PRI3_MASK : iepr_pkg::PRI_MASK;
  endfunction

  // CAN gate forced off on variants without CAN
  localparam logic [15:0] EN4_LIVE = HAS_CAN ? iepr_pkg::EN4_MASK :
    (iepr_pkg::EN4_MASK & ~(16'h0001 << iepr_pkg::EN4_CANTX));

  // ----------------------------------------------------------------
  // Per-source levels: zero code disables the source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < iepr_pkg::NSRC; g++) begin : g_src
      // Field g sits in word g/4, nibble g%4, low three bits
      assign src_lvl[3*g +: 3] = st_r.pri[g/4][4*(g%4) +: 3]; // R3
      assign src_req[g] = src_flag[g] &&
        (src_lvl[3*g +: 3] != iepr_pkg::LVL_OFF); // R2
    end
  endgenerate

  iepr_arb #(.N(iepr_pkg::NSRC)) u_arb (
    .req     (src_req),
    .lvl     (src_lvl),
    .any     (arb_any),
    .win_lvl (arb_lvl),
    .win_id  (arb_id)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    iepr_pkg::iepr_sel_e s;
    logic                acc;
    logic [15:0]         wd;
    logic [iepr_pkg::NEVT-1:0] ev;
    logic [iepr_pkg::NEVT-1:0] clr;
    s      = dec(paddr);
    acc    = psel && penable && !st_r.ready;
    wd     = pwdata[15:0];
    ev     = '0;
    clr    = '0;
    st_nxt = st_r;
    st_nxt.ready = acc;
    st_nxt.err   = acc && (s == iepr_pkg::IEPR_S_NONE);
    st_nxt.rdata = 32'h0000_0000;
    if (acc && pwrite) begin
      // Unimplemented bits are masked on write
      case (s)
        iepr_pkg::IEPR_S_EN3:
          st_nxt.en3 = wd & iepr_pkg::EN3_MASK; // R4 R5 R6
        iepr_pkg::IEPR_S_EN4:
          st_nxt.en4 = wd & EN4_LIVE; // R4 R7
        iepr_pkg::IEPR_S_PRI0: st_nxt.pri[0] = wd & pmask(0); // R4
        iepr_pkg::IEPR_S_PRI1: st_nxt.pri[1] = wd & pmask(1);
        iepr_pkg::IEPR_S_PRI2: st_nxt.pri[2] = wd & pmask(2);
        iepr_pkg::IEPR_S_PRI3: st_nxt.pri[3] = wd & pmask(3);
        iepr_pkg::IEPR_S_CLR:  clr = wd[iepr_pkg::NEVT-1:0];
        iepr_pkg::IEPR_S_IEN:  st_nxt.ien = wd[iepr_pkg::NEVT-1:0];
        default: ;
      endcase
    end else if (acc) begin
      // Read path, stored values already hold zeros in spares
      case (s)
        iepr_pkg::IEPR_S_EN3:  st_nxt.rdata = {16'h0000, st_r.en3};
        iepr_pkg::IEPR_S_EN4:  st_nxt.rdata = {16'h0000, st_r.en4};
        iepr_pkg::IEPR_S_PRI0: st_nxt.rdata = {16'h0000, st_r.pri[0]};
        iepr_pkg::IEPR_S_PRI1: st_nxt.rdata = {16'h0000, st_r.pri[1]};
        iepr_pkg::IEPR_S_PRI2: st_nxt.rdata = {16'h0000, st_r.pri[2]};
        iepr_pkg::IEPR_S_PRI3: st_nxt.rdata = {16'h0000, st_r.pri[3]};
        iepr_pkg::IEPR_S_STAT:
          st_nxt.rdata = {30'h0000_0000, st_r.stat};
        iepr_pkg::IEPR_S_IEN:
          st_nxt.rdata = {30'h0000_0000, st_r.ien};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Request gating toward the controller
    st_nxt.req3 = flag3 & st_r.en3; // R1 R5 R6
    st_nxt.req4 = flag4 & st_r.en4; // R1 R7
    st_nxt.cirq = arb_any;
    st_nxt.clvl = arb_lvl; // R8
    st_nxt.cid  = arb_id;
    // Events: set wins over clear
    ev[iepr_pkg::EVT_PSLV] = acc && (s == iepr_pkg::IEPR_S_NONE);
    ev[iepr_pkg::EVT_WIN]  = arb_any && (arb_id != st_r.cid ||
                             !st_r.cirq);
    st_nxt.stat = (st_r.stat & ~clr) | ev;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.ien);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.en3    <= iepr_pkg::EN_RST; // R9
      st_r.en4    <= iepr_pkg::EN_RST;
      st_r.pri[0] <= iepr_pkg::PRI_RST; // R9
      st_r.pri[1] <= iepr_pkg::PRI_RST;
      st_r.pri[2] <= iepr_pkg::PRI_RST;
      st_r.pri[3] <= iepr_pkg::PRI3_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.err;
  assign req3    = st_r.req3;
  assign req4    = st_r.req4;
  assign cpu_irq = st_r.cirq;
  assign cpu_lvl = st_r.clvl;
  assign cpu_id  = st_r.cid;
  assign irq     = st_r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_GATE3: assert property (@(posedge pclk) disable iff (!presetn)
    req3 == ($past(flag3) & $past(st_r.en3)))
    else $error("word3 gating wrong"); // R1
  AST_SPARE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.en3 & ~iepr_pkg::EN3_MASK) == 16'h0000 &&
    (st_r.pri[0] & ~iepr_pkg::PRI_MASK) == 16'h0000)
    else $error("spare bit set"); // R4
  AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq |-> cpu_lvl != iepr_pkg::LVL_OFF)
    else $error("zero level raised request"); // R2
  AST_LVL: assert property (@(posedge pclk) disable iff (!presetn)
    $past(arb_any) |-> cpu_lvl == $past(arb_lvl))
    else $error("level not forwarded"); // R3
  AST_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    req3[iepr_pkg::EN3_CAL] |-> $past(st_r.en3[iepr_pkg::EN3_CAL]))
    else $error("calendar passed while gated"); // R5
  AST_DMA5: assert property (@(posedge pclk) disable iff (!presetn)
    req3[iepr_pkg::EN3_DMA5] |-> $past(flag3[iepr_pkg::EN3_DMA5]))
    else $error("dma5 request without flag"); // R6
  AST_CAN: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_CAN |-> !req4[iepr_pkg::EN4_CANTX])
    else $error("can request on variant without can"); // R7
  AST_TOP: assert property (@(posedge pclk) disable iff (!presetn)
    $past(src_req[0]) && $past(src_lvl[2:0]) == 3'h7 |->
    cpu_lvl == 3'h7)
    else $error("level seven lost"); // R8
  AST_RST: assert property (@(posedge pclk)
    $rose(presetn) |-> st_r.pri[1] == iepr_pkg::PRI_RST &&
    st_r.en4 == iepr_pkg::EN_RST)
    else $error("reset values wrong"); // R9

  // ----------------------------------------------------------------
  // Further checks on gating, spares, answers, arbitration and reset
  // ----------------------------------------------------------------
  // Word 4 gating follows its flags one cycle late
  AST_GATE4: assert property (@(posedge pclk) disable iff (!presetn)
    req4 == ($past(flag4) & $past(st_r.en4)))
    else $error("word4 gating wrong"); // R1
  // Spare bits of word 4 and priority words 1 and 2 stay clear
  AST_SPARE_HI: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.en4 & ~iepr_pkg::EN4_MASK) == 16'h0000 &&
    (st_r.pri[1] & ~iepr_pkg::PRI_MASK) == 16'h0000 &&
    (st_r.pri[2] & ~iepr_pkg::PRI_MASK) == 16'h0000)
    else $error("spare bit set in upper words"); // R4
  // The top field of priority word 3 is spare as well
  AST_SPARE_PRI3: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.pri[3] & ~iepr_pkg::PRI3_MASK) == 16'h0000)
    else $error("spare bit set in priority word3"); // R4
  // Registers are at most 16 bits wide; the upper half always reads zero
  AST_RDZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero"); // R4
  // An error answer comes with ready and carries no data
  AST_ERRZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data"); // R4
  // The answer stands for one cycle only
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long"); // R4
  // The processor request follows the arbiter exactly
  AST_ANY: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq == $past(arb_any))
    else $error("processor request not forwarded"); // R2
  // With no level-qualified request nothing may reach the core
  AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    $past(src_req) == 15'h0000 |-> !cpu_irq)
    else $error("request without a live level"); // R2
  // A winner is always one of the prioritised sources
  AST_ID: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq |-> cpu_id < iepr_pkg::NSRC)
    else $error("winner index out of range"); // R3
  // Calendar request needs its own flag
  AST_CAL_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    req3[iepr_pkg::EN3_CAL] |-> $past(flag3[iepr_pkg::EN3_CAL]))
    else $error("calendar request without flag"); // R5
  // DMA ch5 request needs its enable
  AST_DMA5_EN: assert property (@(posedge pclk) disable iff (!presetn)
    req3[iepr_pkg::EN3_DMA5] |-> $past(st_r.en3[iepr_pkg::EN3_DMA5]))
    else $error("dma5 passed while gated"); // R6
  // Without CAN the stored gate itself never sets
  AST_CAN_EN: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_CAN |-> !st_r.en4[iepr_pkg::EN4_CANTX])
    else $error("can gate stored on variant without can"); // R7
  // Word 3 and enable word 3 also come out of reset right
  AST_RST3: assert property (@(posedge pclk)
    $rose(presetn) |-> st_r.pri[3] == iepr_pkg::PRI3_RST &&
    st_r.en3 == iepr_pkg::EN_RST)
    else $error("reset values of word3 wrong"); // R9

endmodule // iepr_top

/* File: tb/interrupt_enable_priority_regs_tb_top.sv */
// Self-checking bench for the enable and priority register slice.
// Assumes iepr_top with HAS_CAN at its default and an APB answer per access.
`timescale 1ns/1ps

module interrupt_enable_priority_regs_tb_top;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] flag3, flag4, req3, req4, d3, d4;
  logic [14:0] src_flag;
  logic        cpu_irq, irq, e;
  logic [2:0]  cpu_lvl;
  logic [4:0]  cpu_id;
  logic [63:0] pv;       // Model of the four priority words
  logic [8:0]  ex;       // Expected {irq, level, id}
  int          bad_count, cmp_count, w;

  iepr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag3(flag3),
    .flag4(flag4), .src_flag(src_flag), .req3(req3), .req4(req4),
    .cpu_irq(cpu_irq), .cpu_lvl(cpu_lvl), .cpu_id(cpu_id), .irq(irq));

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count; case inequality so X never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready, bounded so a hang is reported
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    chk(32'(n < 16), 32'h1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Implemented bits per word; everything else reads zero
  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      8'h00: msk = 16'h6000;   // Calendar and DMA ch5 gates only
      8'h04: msk = 16'h007e;   // Bits 6 down to 1
      8'h14: msk = 16'h0777;   // Top field of word 3 is spare
      default: msk = 16'h7777; // Spare bit above each field
    endcase
  endfunction

  // Highest nonzero level wins; strict compare keeps the lowest index
  function automatic logic [8:0] arb(input logic [14:0] f,
                                     input logic [63:0] p);
    logic [2:0] bl;
    logic [4:0] bi;
    bl = 3'h0;
    bi = 5'h0;
    for (int i = 0; i < 15; i++)
      if (f[i] && p[4*i +: 3] > bl) begin
        bl = p[4*i +: 3];
        bi = 5'(i);
      end
    arb = {bl != 3'h0, bl, bi};
  endfunction

  task automatic end_of_test;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; flag3 = 16'h0; flag4 = 16'h0;
    src_flag = 15'h0; bad_count = 0; cmp_count = 0;
    void'($urandom(34734));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then all-ones and random writes read back masked
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(q, {16'h0, (a < 8) ? 16'h0000 : 16'h4444 & msk(8'(a))});
      apb(1'b1, 8'(a), 32'hffffffff);
      apb(1'b0, 8'(a), 32'h0);
      chk(q, {16'h0, msk(8'(a))});
      d3 = 16'($urandom);
      apb(1'b1, 8'(a), {16'($urandom), d3});
      apb(1'b0, 8'(a), 32'h0);
      chk(q, {16'h0, d3 & msk(8'(a))});
    end
    // Unmapped place: read zero with an error
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("test registers done");
    // Enable gating of flags onto requests
    for (int i = 0; i < 10; i++) begin
      d3 = (i == 0) ? 16'hffff : 16'($urandom);
      d4 = (i == 0) ? 16'hffff : 16'($urandom);
      apb(1'b1, iepr_pkg::OFS_EN3, {16'h0, d3});
      apb(1'b1, iepr_pkg::OFS_EN4, {16'h0, d4});
      flag3 <= (i == 0) ? 16'hffff : 16'($urandom);
      flag4 <= (i == 0) ? 16'hffff : 16'($urandom);
      repeat (3) @(posedge pclk);
      chk({16'h0, req3}, {16'h0, flag3 & d3 & 16'h6000});
      chk({16'h0, req4}, {16'h0, flag4 & d4 & 16'h007e});
    end
    $display("test enables done");
    // Codes 0..7 on one source, then random words and flags
    for (int a = 8; a < 24; a += 4) apb(1'b1, 8'(a), 32'h0);
    pv = 64'h0;
    for (int i = 0; i < 48; i++) begin
      w = (i < 8) ? 0 : int'($urandom_range(3));
      d3 = (i < 8) ? 16'(i) : 16'($urandom);
      apb(1'b1, 8'(8 + 4 * w), {16'h0, d3});
      pv[16*w +: 16] = d3 & msk(8'(8 + 4 * w));
      src_flag <= (i < 8) ? 15'h0001 : 15'($urandom);
      repeat (3) @(posedge pclk);
      ex = arb(src_flag, pv);
      chk(32'(cpu_irq), 32'(ex[8]));
      if (ex[8]) chk({24'h0, cpu_lvl, cpu_id}, {24'h0, ex[7:0]});
    end
    $display("test priorities done");
    // Sticky status, enable mask and clear of the event interrupt
    apb(1'b1, iepr_pkg::OFS_CLR, 32'h3);
    apb(1'b1, iepr_pkg::OFS_IEN, 32'h1);
    apb(1'b0, 8'hfc, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b0, iepr_pkg::OFS_STAT, 32'h0);
    chk(32'(q[0]), 32'h1);
    apb(1'b1, iepr_pkg::OFS_IEN, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, iepr_pkg::OFS_IEN, 32'h1);
    apb(1'b1, iepr_pkg::OFS_CLR, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, iepr_pkg::OFS_STAT, 32'h0);
    chk(32'(q[0]), 32'h0);
    $display("test interrupt done");
    end_of_test;
  end
endmodule // interrupt_enable_priority_regs_tb_top
